/* bfs_breaker.sv */
`timescale 1ns/1ps

// ==========================================================
// Monitored breaker: contacts and load current
// ==========================================================
module bfs_breaker #(
  parameter P_OPEN_CYC = 2
) (
  // Clock
  input wire i_clk,
  // Command and mode: 0 stuck, 1 opens, 2 contacts lie open, 3 current lies low
  input wire i_cmd,
  input wire [1:0] i_mode,
  input wire [15:0] i_hi_amps,
  input wire [15:0] i_lo_amps,
  // Feedback towards the relay
  output wire o_open,
  output wire o_closed,
  output wire [15:0] o_amps
);
  reg [3:0] cnt = 4'h0;
  wire moved;
  assign moved = (cnt == P_OPEN_CYC);
  // Travel takes a few cycles; recloses as soon as the command goes away
  always @(posedge i_clk) begin
    if (!i_cmd) cnt <= 4'h0;
    else if (!moved) cnt <= cnt + 4'h1;
  end
  // Faulty modes make one feedback disagree with the real pole state
  assign o_open = moved && (i_mode == 2'h1 || i_mode == 2'h2);
  assign o_closed = !o_open;
  assign o_amps = (moved && i_mode[0]) ? i_lo_amps : i_hi_amps;
endmodule

/* bfs_defs.vh */
`ifndef BFS_DEFS_VH
`define BFS_DEFS_VH

// ==========================================================
// Register map, byte offsets on the APB
// ==========================================================
`define BFS_ADDR_W 8
`define BFS_OFF_CTRL 8'h00
`define BFS_OFF_DELAY 8'h04
`define BFS_OFF_THRESH 8'h08
`define BFS_OFF_STATUS 8'h0C
`define BFS_OFF_CURRENT 8'h10
`define BFS_OFF_TIMER 8'h14
`define BFS_OFF_ACK 8'h18
`define BFS_OFF_IRQ_STAT 8'h1C
`define BFS_OFF_IRQ_EN 8'h20
`define BFS_OFF_IRQ_CLR 8'h24

// ==========================================================
// Control register fields
// ==========================================================
`define BFS_CTRL_EN 0
`define BFS_CTRL_SCH_LSB 1
`define BFS_CTRL_SCH_W 2
`define BFS_CTRL_RELAY 3
`define BFS_CTRL_LINK 4
`define BFS_CTRL_TMSK_LSB 8

// Detection scheme codes; the spare code acts as combined
`define BFS_SCH_CURRENT 2'h0
`define BFS_SCH_POSITION 2'h1
`define BFS_SCH_COMBINED 2'h2

// ==========================================================
// Status register fields
// ==========================================================
`define BFS_ST_STATE_LSB 0
`define BFS_ST_LOCK 2
`define BFS_ST_TRIP 3
`define BFS_ST_OPENED 4
`define BFS_ST_CURHI 5
`define BFS_ST_POSOPEN 6
`define BFS_ST_RUN 7

// ==========================================================
// Interrupt and acknowledge fields
// ==========================================================
`define BFS_IRQ_TRIP 0
`define BFS_IRQ_REJECT 1
`define BFS_IRQ_START 2
`define BFS_IRQ_W 3
`define BFS_ACK_LOCK 0

// ==========================================================
// Reset values and timing
// ==========================================================
`define BFS_EN_RST 1'h0
`define BFS_SCH_RST 2'h0
`define BFS_RELAY_RST 1'h1
`define BFS_LINK_RST 1'h0
`define BFS_THRESH_RST 16'h0100
`define BFS_IRQ_EN_RST 3'h0
`define BFS_CLK_MHZ 200
`define BFS_DELAY_US_DEF 100

`endif

/* bfs_sync.v */
`timescale 1ns/1ps

// ==========================================================
// Pin synchroniser with agreement filter
// ==========================================================
module bfs_sync #(
  parameter P_WIDTH = 3
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Asynchronous pins in, clean levels out
  input wire [P_WIDTH-1:0] i_async,
  output wire [P_WIDTH-1:0] o_sync
);

  reg [P_WIDTH-1:0] meta_reg;
  reg [P_WIDTH-1:0] stage2_reg;
  reg [P_WIDTH-1:0] stage3_reg;
  reg [P_WIDTH-1:0] level_reg;

  genvar g;
  generate
    for (g = 0; g < P_WIDTH; g = g + 1) begin : g_bit
      // The first stage feeds the second only; a level counts once two later stages agree
      always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_reg[g] <= 1'h0;
          stage2_reg[g] <= 1'h0;
          stage3_reg[g] <= 1'h0;
          level_reg[g] <= 1'h0;
        end else begin
          meta_reg[g] <= i_async[g];
          stage2_reg[g] <= meta_reg[g];
          stage3_reg[g] <= stage2_reg[g];
          if (stage2_reg[g] == stage3_reg[g]) begin
            level_reg[g] <= stage3_reg[g];
          end
        end
      end
    end
  endgenerate

  assign o_sync = level_reg;

endmodule

/* bfs_timer.v */
`timescale 1ns/1ps

// ==========================================================
// Supervision delay timer
// ==========================================================
module bfs_timer #(
  parameter P_CNT_W = 32
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Control
  input wire i_start,
  input wire i_stop,
  input wire [P_CNT_W-1:0] i_delay,
  // Status
  output wire o_expired,
  output wire o_running,
  output wire [P_CNT_W-1:0] o_count
);

  reg [P_CNT_W-1:0] cnt_reg;
  reg run_reg;
  wire [P_CNT_W-1:0] last_cnt;

  // A zero delay behaves as one cycle so expiry cannot be skipped
  assign last_cnt = (i_delay == {P_CNT_W{1'b0}}) ? {P_CNT_W{1'b0}} :
                    i_delay - {{(P_CNT_W-1){1'b0}}, 1'b1};

  // Start wins over stop so a fresh trigger is never dropped
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= {P_CNT_W{1'b0}};
      run_reg <= 1'h0;
    end else if (i_start) begin
      cnt_reg <= {P_CNT_W{1'b0}};
      run_reg <= 1'h1;
    end else if (i_stop) begin
      cnt_reg <= {P_CNT_W{1'b0}};
      run_reg <= 1'h0;
    end else if (run_reg && (cnt_reg != last_cnt)) begin
      cnt_reg <= cnt_reg + {{(P_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Expiry holds until the owner stops the timer
  assign o_expired = run_reg && (cnt_reg == last_cnt);
  assign o_running = run_reg;
  assign o_count = cnt_reg;

endmodule

/* bfs_top.v */
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "bfs_defs.vh"

module bfs_top #(
  parameter P_NTRIG = 4,
  parameter P_CUR_W = 16,
  parameter [31:0] P_DELAY_CYC = `BFS_DELAY_US_DEF * `BFS_CLK_MHZ
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`BFS_ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Trip sources and measurement, same clock domain
  input wire [P_NTRIG-1:0] i_trip_src,
  input wire [P_CUR_W-1:0] i_phase_current,
  // Breaker contacts and acknowledge key, asynchronous pins
  input wire i_pos_open_contact,
  input wire i_pos_closed_contact,
  input wire i_lock_ack_pin,
  // Upstream backup trip and lockout, host interrupt
  output wire o_backup_trip_relay,
  output wire o_backup_trip_link,
  output wire o_lockout,
  output wire o_irq
);

  // ==========================================================
  // States
  // ==========================================================
  localparam ST_STANDBY = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_REJECT = 2'h2;
  localparam ST_TRIP = 2'h3;

  // ==========================================================
  // Declarations
  // ==========================================================
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_b_int;
  wire [2:0] pin_sync;
  wire pos_open_s;
  wire pos_closed_s;
  wire ack_pin_s;
  reg ack_pin_prev_reg;
  reg en_reg;
  reg [`BFS_CTRL_SCH_W-1:0] scheme_reg;
  reg relay_en_reg;
  reg link_en_reg;
  reg [P_NTRIG-1:0] tmask_reg;
  reg [31:0] delay_reg;
  reg [P_CUR_W-1:0] thresh_reg;
  reg [`BFS_IRQ_W-1:0] irq_stat_reg;
  reg [`BFS_IRQ_W-1:0] irq_stat_next;
  reg [`BFS_IRQ_W-1:0] irq_en_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg trip_reg;
  reg relay_reg;
  reg link_reg;
  reg lock_reg;
  reg lock_next;
  reg irq_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg timer_start;
  reg timer_stop;
  reg ev_start;
  reg ev_reject;
  reg ev_trip;
  wire timer_expired;
  wire timer_running;
  wire [31:0] timer_count;
  wire trig_any;
  wire cur_high;
  wire pos_open;
  wire breaker_opened;
  wire wr_en;
  wire rd_setup;
  wire ack_req;
  wire [`BFS_IRQ_W-1:0] irq_set;

  // ==========================================================
  // Functions
  // ==========================================================
  // Address decode for the error answer only; the read mux decodes on its own
  function addr_valid;
    input [`BFS_ADDR_W-1:0] addr;
    begin
      case (addr)
        `BFS_OFF_CTRL, `BFS_OFF_DELAY, `BFS_OFF_THRESH, `BFS_OFF_STATUS,
        `BFS_OFF_CURRENT, `BFS_OFF_TIMER, `BFS_OFF_ACK, `BFS_OFF_IRQ_STAT,
        `BFS_OFF_IRQ_EN, `BFS_OFF_IRQ_CLR: addr_valid = 1'b1;
        default: addr_valid = 1'b0;
      endcase
    end
  endfunction

  // Opening judgement per scheme
  function opened_by_scheme;
    input [`BFS_CTRL_SCH_W-1:0] sch;
    input cur_hi;
    input p_open;
    begin
      case (sch)
        `BFS_SCH_CURRENT: opened_by_scheme = ~cur_hi;
        `BFS_SCH_POSITION: opened_by_scheme = p_open;
        // Failure needs both signs, so either sign of opening stops it
        default: opened_by_scheme = ~cur_hi | p_open;
      endcase
    end
  endfunction

  // ==========================================================
  // Reset release
  // ==========================================================
  // Assertion is immediate, release waits two edges
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'h0;
      rst_sync_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_b_int = rst_sync_reg;

  // ==========================================================
  // Pin inputs and timer
  // ==========================================================
  bfs_sync #(
    .P_WIDTH(3)
  ) u_pin_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(rst_b_int),
    .i_async({i_lock_ack_pin, i_pos_closed_contact, i_pos_open_contact}),
    .o_sync(pin_sync)
  );
  assign pos_open_s = pin_sync[0];
  assign pos_closed_s = pin_sync[1];
  assign ack_pin_s = pin_sync[2];

  bfs_timer #(
    .P_CNT_W(32)
  ) u_timer (
    .i_clk(i_ref_clk),
    .i_rst_b(rst_b_int),
    .i_start(timer_start),
    .i_stop(timer_stop),
    .i_delay(delay_reg),
    .o_expired(timer_expired),
    .o_running(timer_running),
    .o_count(timer_count)
  );

  // ==========================================================
  // Opening detection
  // ==========================================================
  // Contacts count as open only when they agree, guarding a stuck contact
  assign pos_open = pos_open_s & ~pos_closed_s;
  assign cur_high = (i_phase_current >= thresh_reg);
  assign breaker_opened = opened_by_scheme(scheme_reg, cur_high, pos_open);
  assign trig_any = en_reg & (|(i_trip_src & tmask_reg));

  // ==========================================================
  // Supervision state machine
  // ==========================================================
  // Opening and expiry in one cycle favour the breaker having opened
  always @* begin
    state_next = state_reg;
    timer_start = 1'b0;
    timer_stop = 1'b0;
    ev_start = 1'b0;
    ev_reject = 1'b0;
    ev_trip = 1'b0;
    case (state_reg)
      ST_STANDBY: begin
        if (trig_any) begin
          state_next = ST_RUN;
          timer_start = 1'b1;
          ev_start = 1'b1;
        end
      end
      ST_RUN: begin
        // The trigger is looked at only once opening is seen, so it may drop freely before
        if (breaker_opened) begin
          timer_stop = 1'b1;
          if (trig_any) begin
            state_next = ST_REJECT;
            ev_reject = 1'b1;
          end else begin
            state_next = ST_STANDBY;
          end
        end else if (timer_expired) begin
          state_next = ST_TRIP;
          timer_stop = 1'b1;
          ev_trip = 1'b1;
        end
      end
      ST_REJECT: begin
        if (!trig_any) begin
          state_next = ST_STANDBY;
        end
      end
      ST_TRIP: begin
        // Backup trip holds while the fault is still being tripped
        if (!trig_any) begin
          state_next = ST_STANDBY;
        end
      end
      default: begin
        state_next = ST_STANDBY;
      end
    endcase
  end

  // Lockout: a new failure wins over a same-cycle acknowledge
  assign ack_req = (wr_en && (i_paddr == `BFS_OFF_ACK) && i_pwdata[`BFS_ACK_LOCK]) ||
                   (ack_pin_s && !ack_pin_prev_reg);
  always @* begin
    lock_next = lock_reg;
    if (ev_trip) begin
      lock_next = 1'b1;
    end else if (ack_req) begin
      lock_next = 1'b0;
    end
  end

  // State, trip routing and lockout flops
  always @(posedge i_ref_clk or negedge rst_b_int) begin
    if (!rst_b_int) begin
      state_reg <= ST_STANDBY;
      trip_reg <= 1'h0;
      relay_reg <= 1'h0;
      link_reg <= 1'h0;
      lock_reg <= 1'h0;
      ack_pin_prev_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      trip_reg <= (state_next == ST_TRIP);
      relay_reg <= (state_next == ST_TRIP) & relay_en_reg;
      link_reg <= (state_next == ST_TRIP) & link_en_reg;
      lock_reg <= lock_next;
      ack_pin_prev_reg <= ack_pin_s;
    end
  end

  assign o_backup_trip_relay = relay_reg;
  assign o_backup_trip_link = link_reg;
  assign o_lockout = lock_reg;

  // ==========================================================
  // APB slave
  // ==========================================================
  // Zero wait states; read data is fetched in the setup cycle
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign o_pready = 1'h1;
  assign o_pslverr = i_psel & i_penable & ~addr_valid(i_paddr);

  // Configuration registers
  always @(posedge i_ref_clk or negedge rst_b_int) begin
    if (!rst_b_int) begin
      en_reg <= `BFS_EN_RST;
      scheme_reg <= `BFS_SCH_RST;
      relay_en_reg <= `BFS_RELAY_RST;
      link_en_reg <= `BFS_LINK_RST;
      tmask_reg <= {P_NTRIG{1'b1}};
      delay_reg <= P_DELAY_CYC;
      thresh_reg <= `BFS_THRESH_RST;
      irq_en_reg <= `BFS_IRQ_EN_RST;
    end else if (wr_en) begin
      case (i_paddr)
        `BFS_OFF_CTRL: begin
          en_reg <= i_pwdata[`BFS_CTRL_EN];
          scheme_reg <= i_pwdata[`BFS_CTRL_SCH_LSB +: `BFS_CTRL_SCH_W];
          relay_en_reg <= i_pwdata[`BFS_CTRL_RELAY];
          link_en_reg <= i_pwdata[`BFS_CTRL_LINK];
          tmask_reg <= i_pwdata[`BFS_CTRL_TMSK_LSB +: P_NTRIG];
        end
        `BFS_OFF_DELAY: delay_reg <= i_pwdata;
        `BFS_OFF_THRESH: thresh_reg <= i_pwdata[P_CUR_W-1:0];
        `BFS_OFF_IRQ_EN: irq_en_reg <= i_pwdata[`BFS_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; unused bits read as zero
  always @* begin
    rdata_next = 32'h0000_0000;
    case (i_paddr)
      `BFS_OFF_CTRL: begin
        rdata_next[`BFS_CTRL_EN] = en_reg;
        rdata_next[`BFS_CTRL_SCH_LSB +: `BFS_CTRL_SCH_W] = scheme_reg;
        rdata_next[`BFS_CTRL_RELAY] = relay_en_reg;
        rdata_next[`BFS_CTRL_LINK] = link_en_reg;
        rdata_next[`BFS_CTRL_TMSK_LSB +: P_NTRIG] = tmask_reg;
      end
      `BFS_OFF_DELAY: rdata_next = delay_reg;
      `BFS_OFF_THRESH: rdata_next[P_CUR_W-1:0] = thresh_reg;
      `BFS_OFF_STATUS: begin
        rdata_next[`BFS_ST_STATE_LSB +: 2] = state_reg;
        rdata_next[`BFS_ST_LOCK] = lock_reg;
        rdata_next[`BFS_ST_TRIP] = trip_reg;
        rdata_next[`BFS_ST_OPENED] = breaker_opened;
        rdata_next[`BFS_ST_CURHI] = cur_high;
        rdata_next[`BFS_ST_POSOPEN] = pos_open;
        rdata_next[`BFS_ST_RUN] = timer_running;
      end
      `BFS_OFF_CURRENT: rdata_next[P_CUR_W-1:0] = i_phase_current;
      `BFS_OFF_TIMER: rdata_next = timer_count;
      `BFS_OFF_IRQ_STAT: rdata_next[`BFS_IRQ_W-1:0] = irq_stat_reg;
      `BFS_OFF_IRQ_EN: rdata_next[`BFS_IRQ_W-1:0] = irq_en_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge i_ref_clk or negedge rst_b_int) begin
    if (!rst_b_int) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_reg <= rdata_next;
    end
  end
  assign o_prdata = rdata_reg;

  // ==========================================================
  // Interrupts
  // ==========================================================
  // Sticky events; a set in the clearing cycle survives the clear
  assign irq_set = {ev_start, ev_reject, ev_trip};
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && (i_paddr == `BFS_OFF_IRQ_CLR)) begin
      irq_stat_next = irq_stat_reg & ~i_pwdata[`BFS_IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_set;
  end

  always @(posedge i_ref_clk or negedge rst_b_int) begin
    if (!rst_b_int) begin
      irq_stat_reg <= {`BFS_IRQ_W{1'b0}};
      irq_reg <= 1'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_en_reg);
    end
  end
  assign o_irq = irq_reg;

endmodule

/* bfs_top_assertions.sv */
`timescale 1ns/1ps
`include "bfs_defs.vh"

// ==========================================================
// Port checks of the supervision block
// ==========================================================
module bfs_chk #(
  parameter P_NTRIG = 4,
  parameter P_CUR_W = 16,
  parameter [31:0] P_DELAY_CYC = 20000
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // APB
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`BFS_ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // Field side
  input wire [P_NTRIG-1:0] i_trip_src,
  input wire [P_CUR_W-1:0] i_phase_current,
  input wire i_pos_open_contact,
  input wire i_pos_closed_contact,
  input wire i_lock_ack_pin,
  input wire o_backup_trip_relay,
  input wire o_backup_trip_link,
  input wire o_lockout,
  input wire o_irq
);
  wire ack_wr;
  reg pin_q;
  reg [3:0] ack_age;
  assign ack_wr = i_psel && i_penable && i_pwrite && (i_paddr == `BFS_OFF_ACK) &&
                  i_pwdata[`BFS_ACK_LOCK];
  // Age of the last acknowledge; saturates so a stale one never excuses a drop
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q <= 1'b0;
      ack_age <= 4'hF;
    end else begin
      pin_q <= i_lock_ack_pin;
      if (ack_wr || (i_lock_ack_pin && !pin_q)) ack_age <= 4'h0;
      else if (ack_age != 4'hF) ack_age <= ack_age + 4'h1;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Key held long enough to pass the pin filter, with no trip meanwhile
  sequence s_pin_ack;
    $rose(i_lock_ack_pin) && !o_backup_trip_relay ##1
      (i_lock_ack_pin && !o_backup_trip_relay)[*8];
  endsequence
  sequence s_trip_entry;
    $rose(o_backup_trip_relay);
  endsequence
  chk_reset_quiet: assert property ($rose(i_rst_b) |-> !o_lockout && !o_backup_trip_relay
    && !o_backup_trip_link && !o_irq)
    else $error("output active right after reset");
  chk_lock_with_trip: assert property (s_trip_entry |-> o_lockout)
    else $error("trip without lockout");
  chk_lock_cause: assert property ($rose(o_lockout) |-> o_backup_trip_relay)
    else $error("lockout without trip");
  chk_lock_hold: assert property ($fell(o_lockout) |-> ack_age < 4'h9)
    else $error("lockout fell without acknowledge");
  chk_ack_write: assert property (ack_wr && !o_backup_trip_relay |=> !o_lockout)
    else $error("acknowledge write kept lockout");
  chk_ack_pin: assert property (s_pin_ack |-> !o_lockout)
    else $error("acknowledge key kept lockout");
  chk_trip_drop: assert property (o_backup_trip_relay && i_trip_src == 0
    |=> !o_backup_trip_relay)
    else $error("trip stayed after triggers fell");
  chk_trip_hold: assert property (o_backup_trip_relay && i_trip_src != 0
    |=> o_backup_trip_relay)
    else $error("trip dropped with trigger active");
  chk_err_phase: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access phase");
endmodule

bind bfs_top bfs_chk #(.P_NTRIG(P_NTRIG), .P_CUR_W(P_CUR_W), .P_DELAY_CYC(P_DELAY_CYC)) u_chk (
  .i_ref_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_trip_src, .i_phase_current, .i_pos_open_contact,
  .i_pos_closed_contact, .i_lock_ack_pin, .o_backup_trip_relay, .o_backup_trip_link,
  .o_lockout, .o_irq);

/* bfs_top_tb.sv */
`timescale 1ns/1ps
`include "bfs_defs.vh"

// ==========================================================
// Self-checking bench of the supervision block
// ==========================================================
module bfs_top_tb;
  localparam [31:0] P_DLY = 32'h8;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] trig = 4'h0;
  reg brk_cmd = 1'b0;
  reg [1:0] mode = 2'h0;
  reg [15:0] hi_amps = 16'h0200;
  reg [15:0] lo_amps = 16'h00FF;
  reg ack_pin = 1'b0;
  wire [31:0] prdata;
  wire [15:0] amps;
  wire pready, pslverr, popen, pclosed, relay, link, lock, irq;
  integer seed = 8;
  integer num_errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer dly, ev, s, m, n, tn;
  reg [31:0] q;
  reg e, ex, lk, lo, ir;

  bfs_top #(.P_DELAY_CYC(P_DLY)) dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_trip_src(trig),
    .i_phase_current(amps), .i_pos_open_contact(popen), .i_pos_closed_contact(pclosed),
    .i_lock_ack_pin(ack_pin), .o_backup_trip_relay(relay), .o_backup_trip_link(link),
    .o_lockout(lock), .o_irq(irq));
  bfs_breaker u_brk (.i_clk(clk), .i_cmd(brk_cmd), .i_mode(mode), .i_hi_amps(hi_amps),
    .i_lo_amps(lo_amps), .o_open(popen), .o_closed(pclosed), .o_amps(amps));

  // ==========================================================
  // Clock, watchdog and reporting
  // ==========================================================
  initial forever #2.5 clk = ~clk;
  // The whole run needs under a thousand cycles; far beyond that means a hang
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk_bit(input [127:0] nm, input exp, input got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %0s expected %b seen %b", nm, exp, got);
    end
  endtask
  task chk_word(input [127:0] nm, input [31:0] exp, input [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; holds the request until pready is seen at an edge
  // Only the watchdog ends a wait that never sees pready
  task apb(input w, input [7:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Output pins are looked at mid-cycle, away from the launching edge
  task pins(input exp_lock, input exp_irq);
    @(negedge clk);
    chk_bit("lockout", exp_lock, lock);
    chk_bit("irq", exp_irq, irq);
    @(posedge clk);
  endtask
  function exp_trip(input integer sc, input integer md);
    reg hi, op;
    hi = (md == 0 || md == 2);
    op = (md == 1 || md == 2);
    exp_trip = (sc == 0) ? hi : (sc == 1) ? !op : (hi && !op);
  endfunction

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `BFS_OFF_CTRL, 32'h0);
    chk_word("ctrl", 32'h00000F08, q);
    apb(1'b0, `BFS_OFF_DELAY, 32'h0);
    chk_word("delay", P_DLY, q);
    apb(1'b0, `BFS_OFF_THRESH, 32'h0);
    chk_word("thresh", 32'h00000100, q);
    apb(1'b0, `BFS_OFF_TIMER, 32'h0);
    chk_word("timer", 32'h0, q);
    apb(1'b0, `BFS_OFF_STATUS, 32'h0);
    chk_word("status", 32'h0, q & 32'h0000000F);
    apb(1'b0, 8'h30, 32'h0);
    chk_bit("rd error", 1'b1, e);
    chk_word("rd unmapped", 32'h0, q);
    apb(1'b1, 8'h30, 32'h5);
    chk_bit("wr error", 1'b1, e);
    chk_bit("pready", 1'b1, pready);
    apb(1'b0, `BFS_OFF_CURRENT, 32'h0);
    chk_word("current", 32'h00000200, q);
    // Triggers while the block is disabled must not start supervision
    trig <= 4'hF;
    repeat (4) @(posedge clk);
    apb(1'b0, `BFS_OFF_STATUS, 32'h0);
    trig <= 4'h0;
    chk_word("disabled", 32'h0, q & 32'h00000083);
    pins(1'b0, 1'b0);
    $display("test reset done");
    dly = 12 + ($random(seed) & 7);
    apb(1'b1, `BFS_OFF_DELAY, dly);
    for (ev = 0; ev < 12; ev = ev + 1) begin
      s = (ev < 8) ? ev / 4 : 2 + ($random(seed) & 1); // Spare code 3 acts as combined
      m = ev % 4;
      ex = exp_trip(s, m);
      apb(1'b1, `BFS_OFF_IRQ_EN, (ev == 0) ? 32'h0 : 32'h1);
      apb(1'b1, `BFS_OFF_CTRL, ((ev == 0) ? 32'h00000F09 : 32'h00000F19) | (s << 1));
      hi_amps <= (ev == 0) ? 16'h0100 : 16'h0101 + ($random(seed) & 16'h03FF);
      mode <= m;
      trig <= 4'h1 << ($random(seed) & 3);
      brk_cmd <= 1'b1;
      tn = 0;
      for (n = 1; n <= dly + 6; n = n + 1) begin
        @(posedge clk);
        if (n == 2 && ex && m != 0) trig <= 4'h0;
        @(negedge clk);
        if (relay === 1'b1 && tn == 0) begin
          tn = n;
          lk = link;
          lo = lock;
          ir = irq;
        end
      end
      @(posedge clk);
      chk_word("trip time", ex ? dly + 1 : 0, tn);
      if (ex) begin
        chk_bit("link trip", ev != 0, lk);
        chk_bit("lock at trip", 1'b1, lo);
        chk_bit("irq at trip", ev != 0, ir);
      end else begin
        apb(1'b0, `BFS_OFF_STATUS, 32'h0);
        chk_word("rejected", 32'h2, q & 32'h3);
      end
      trig <= 4'h0;
      brk_cmd <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b0, `BFS_OFF_STATUS, 32'h0);
      chk_word("standby", ex ? 32'h4 : 32'h0, q & 32'h7);
      apb(1'b0, `BFS_OFF_IRQ_STAT, 32'h0);
      chk_word("irq stat", ex ? 32'h5 : 32'h6, q & 32'h7);
      apb(1'b1, `BFS_OFF_IRQ_CLR, 32'h7);
      apb(1'b0, `BFS_OFF_IRQ_STAT, 32'h0);
      chk_word("irq cleared", 32'h0, q);
      if (ex && ev % 2) apb(1'b1, `BFS_OFF_ACK, 32'h1);
      else if (ex) begin
        ack_pin <= 1'b1;
        repeat (10) @(posedge clk);
        ack_pin <= 1'b0;
        repeat (2) @(posedge clk);
      end
      pins(1'b0, 1'b0);
      $display("test scheme %0d mode %0d done", s, m);
    end
    wrap_up;
  end
endmodule
